// >>> rtl/smlc_line_control.sv
/*
 * modem line and bit-rate control of a network serial bridge port.
 * assumes all inputs are synchronous to sys_clk; the buffer free count,
 * port state and connection state come from the data path.
 */
// How it works
// RQ1: flow override value, when present, wins over the stored flow choice.
// RQ2: flow disabled: cts ignored, rts high unless remote host changes it.
// RQ3: flow enabled: rts high while buffer has room, low below 20 free bytes.
// RQ4: flow enabled: rts low whenever the serial port is closed.
// RQ5: flow enabled: transmit only while cts is sampled high.
// RQ6: attached device lowers cts to pause us and stops when rts low.
// RQ7: flow enabled: remote rts sets ignored but acknowledged ok; notifications ignored.
// RQ8: rts and cts levels readable and monitorable regardless of flow choice.
// RQ9: flow choice has no effect in half-duplex mode.
// RQ10: module variants invert every modem line level.
// RQ11: dtr function 0 idle, 1 connection status; reset 0; applied at reboot.
// RQ12: idle dtr mode: dtr high unless remote host changes it.
// RQ13: connection dtr mode: dtr low without connection, high with one.
// RQ14: dtr level readable and monitorable in either dtr mode.
// RQ15: bit-rate codes 0 to 11 map to the listed rates; reset 5.
// RQ16: new bit rate applied only at reboot or programming mode exit.
// RQ17: selected rate in routing and escape programming; button forces 38400.
// RQ18: flow selector 0 disabled, 1 enabled; reset enabled.
// RQ19: rts and dtr each pass through one configurable output inversion.
`timescale 1ns/100ps
module smlc_line_control (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// stored settings and overrides
	input wire smlc_pkg::smlc_cfg_s cfg_in,
	input wire logic flow_ctrl_override_valid,
	input wire logic flow_ctrl_override,
	input wire logic bit_rate_override_valid,
	input wire logic [3:0] bit_rate_override,
	input wire logic module_variant,
	input wire logic half_duplex,
	// system events and modes
	input wire logic reboot,
	input wire logic prog_mode,
	input wire logic prog_by_button,
	// data path state
	input wire logic port_open,
	input wire logic connection_active,
	input wire logic [15:0] s2n_free_bytes,
	// remote pin commands
	input wire smlc_pkg::smlc_pin_cmd_s pin_cmd,
	output logic pin_ack_ff,
	output logic pin_ok_ff,
	output logic pin_rd_level_ff,
	// change monitoring
	input wire logic [2:0] monitor_en,
	output logic [2:0] notify_change,
	// serial lines
	input wire logic cts_pin,
	output logic rts_pin,
	output logic dtr_pin,
	output logic tx_allow,
	// active settings
	output smlc_pkg::smlc_cfg_s applied_cfg_ff,
	output logic [3:0] active_rate_code,
	output logic [19:0] bit_period_cycles_ff
);

	// ****************************************************************
	// settings application
	// ****************************************************************
	logic prog_prev_ff;
	logic prog_exit;
	logic apply_serial;
	logic rate_code_ok;
	smlc_pkg::smlc_cfg_s nxt_applied_cfg;

	assign prog_exit = prog_prev_ff & ~prog_mode;
	assign apply_serial = reboot | prog_exit; // RQ16
	assign rate_code_ok = cfg_in.bit_rate_select <= smlc_pkg::BIT_RATE_LAST;

	always_comb begin
		nxt_applied_cfg = applied_cfg_ff;
		if (apply_serial) begin
			nxt_applied_cfg.flow_ctrl_select = cfg_in.flow_ctrl_select; // RQ18
			if (rate_code_ok) begin
				nxt_applied_cfg.bit_rate_select = cfg_in.bit_rate_select; // RQ16
			end
		end
		if (reboot) begin
			nxt_applied_cfg.dtr_function_select = cfg_in.dtr_function_select; // RQ11
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			applied_cfg_ff <= smlc_pkg::CFG_RESET; // RQ11 RQ15 RQ18
			prog_prev_ff <= 1'b0;
		end else begin
			applied_cfg_ff <= nxt_applied_cfg;
			prog_prev_ff <= prog_mode;
		end
	end

	// ****************************************************************
	// flow control
	// ****************************************************************
	logic eff_flow;
	logic flow_active;
	logic cts_level;
	logic buf_room;
	logic rts_level;

	assign eff_flow = flow_ctrl_override_valid ? flow_ctrl_override
		: applied_cfg_ff.flow_ctrl_select; // RQ1
	assign flow_active = (eff_flow == smlc_pkg::FLOW_CTRL_ENABLED) & ~half_duplex; // RQ9
	assign cts_level = cts_pin ^ module_variant; // RQ10
	assign buf_room = s2n_free_bytes >= smlc_pkg::RTS_FREE_MIN; // RQ3
	assign tx_allow = flow_active ? cts_level : 1'b1; // RQ5 RQ2

	// ****************************************************************
	// remote pin control
	// ****************************************************************
	logic rts_host_ff;
	logic dtr_host_ff;
	logic nxt_rts_host;
	logic nxt_dtr_host;
	logic cmd_write;
	logic cmd_get;
	logic cmd_reply;
	logic nxt_rd_level;
	logic dtr_level;

	assign cmd_write = pin_cmd.valid & ((pin_cmd.op == smlc_pkg::PIN_OP_SET) | (pin_cmd.op == smlc_pkg::PIN_OP_NOTIFY));
	assign cmd_get = pin_cmd.valid & (pin_cmd.op == smlc_pkg::PIN_OP_GET);
	assign cmd_reply = pin_cmd.valid & (pin_cmd.op != smlc_pkg::PIN_OP_NOTIFY);

	always_comb begin
		nxt_rts_host = rts_host_ff;
		nxt_dtr_host = dtr_host_ff;
		if (reboot) begin
			nxt_rts_host = smlc_pkg::LINE_HIGH; // RQ2
			nxt_dtr_host = smlc_pkg::LINE_HIGH; // RQ12
		end else if (cmd_write) begin
			if (pin_cmd.pin == smlc_pkg::PIN_RTS && !flow_active) begin
				nxt_rts_host = pin_cmd.level; // RQ2 RQ7
			end
			if (pin_cmd.pin == smlc_pkg::PIN_DTR) begin
				nxt_dtr_host = pin_cmd.level; // RQ12
			end
		end
	end

	assign rts_level = flow_active ? (port_open & buf_room) : rts_host_ff; // RQ3 RQ4 RQ2
	assign dtr_level = (applied_cfg_ff.dtr_function_select == smlc_pkg::DTR_FUNC_CONN)
		? connection_active : dtr_host_ff; // RQ13 RQ12

	always_comb begin
		case (pin_cmd.pin)
			smlc_pkg::PIN_RTS: nxt_rd_level = rts_level; // RQ8
			smlc_pkg::PIN_CTS: nxt_rd_level = cts_level; // RQ8
			smlc_pkg::PIN_DTR: nxt_rd_level = dtr_level; // RQ14
			default: nxt_rd_level = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			rts_host_ff <= smlc_pkg::LINE_HIGH;
			dtr_host_ff <= smlc_pkg::LINE_HIGH;
			pin_ack_ff <= 1'b0;
			pin_ok_ff <= 1'b0;
			pin_rd_level_ff <= 1'b0;
		end else begin
			rts_host_ff <= nxt_rts_host;
			dtr_host_ff <= nxt_dtr_host;
			pin_ack_ff <= cmd_reply;
			pin_ok_ff <= cmd_reply; // RQ7
			pin_rd_level_ff <= cmd_get ? nxt_rd_level : 1'b0;
		end
	end

	// ****************************************************************
	// line outputs with variant inversion
	// ****************************************************************
	smlc_line_out u_rts_out (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.level(rts_level),
		.invert(module_variant), // RQ19
		.pin_ff(rts_pin)
	);

	smlc_line_out u_dtr_out (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.level(dtr_level),
		.invert(module_variant), // RQ19
		.pin_ff(dtr_pin)
	);

	// ****************************************************************
	// change monitoring
	// ****************************************************************
	smlc_change_det u_mon_rts (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.level(rts_level),
		.enable(monitor_en[smlc_pkg::MON_RTS]), // RQ8
		.change_ff(notify_change[smlc_pkg::MON_RTS])
	);

	smlc_change_det u_mon_cts (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.level(cts_level),
		.enable(monitor_en[smlc_pkg::MON_CTS]), // RQ8
		.change_ff(notify_change[smlc_pkg::MON_CTS])
	);

	smlc_change_det u_mon_dtr (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.level(dtr_level),
		.enable(monitor_en[smlc_pkg::MON_DTR]), // RQ14
		.change_ff(notify_change[smlc_pkg::MON_DTR])
	);

	// ****************************************************************
	// bit rate selection
	// ****************************************************************
	logic override_ok;
	logic [3:0] routing_rate;

	assign override_ok = bit_rate_override_valid & (bit_rate_override <= smlc_pkg::BIT_RATE_LAST);
	assign routing_rate = override_ok ? bit_rate_override : applied_cfg_ff.bit_rate_select;
	assign active_rate_code = !prog_mode ? routing_rate
		: prog_by_button ? smlc_pkg::BIT_RATE_BUTTON
		: applied_cfg_ff.bit_rate_select; // RQ17

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			bit_period_cycles_ff <= smlc_pkg::BIT_CYCLES[smlc_pkg::BIT_RATE_RESET];
		end else begin
			bit_period_cycles_ff <= smlc_pkg::BIT_CYCLES[active_rate_code]; // RQ15
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_flow_override: assert property (flow_ctrl_override_valid && !half_duplex // RQ1
		|-> tx_allow == (flow_ctrl_override ? (cts_pin ^ module_variant) : 1'b1))
		else $error("flow override not taking precedence");

	a_rts_room_high: assert property (flow_active && port_open && buf_room // RQ3
		|=> rts_pin == ~$past(module_variant))
		else $error("rts not high with buffer room");

	a_rts_full_low: assert property (flow_active && !buf_room |=> rts_pin == $past(module_variant)) // RQ3
		else $error("rts not low below free threshold");

	a_rts_closed_low: assert property (flow_active && !port_open |=> rts_pin == $past(module_variant)) // RQ4
		else $error("rts not low while port closed");

	a_tx_cts_hold: assert property (flow_active && (cts_pin == module_variant) |-> !tx_allow) // RQ5
		else $error("transmit allowed while cts low");

	a_tx_flow_off: assert property ((half_duplex || (flow_ctrl_override_valid ? !flow_ctrl_override // RQ2 RQ9
		: !applied_cfg_ff.flow_ctrl_select)) |-> tx_allow)
		else $error("cts not ignored without flow control");

	a_rts_set_ignored: assert property (flow_active && cmd_write && pin_cmd.pin == smlc_pkg::PIN_RTS && !reboot // RQ7
		|=> $stable(rts_host_ff) && (pin_ok_ff || $past(pin_cmd.op) == smlc_pkg::PIN_OP_NOTIFY))
		else $error("remote rts write took effect under flow control");

	a_dtr_conn_level: assert property (applied_cfg_ff.dtr_function_select == smlc_pkg::DTR_FUNC_CONN // RQ13
		|=> dtr_pin == ($past(connection_active) ^ $past(module_variant)))
		else $error("dtr does not follow connection status");

	a_dtr_idle_set: assert property (applied_cfg_ff.dtr_function_select == smlc_pkg::DTR_FUNC_IDLE // RQ12
		&& cmd_write && pin_cmd.pin == smlc_pkg::PIN_DTR && !reboot && !$changed(applied_cfg_ff)
		|=> ##1 dtr_pin == ($past(pin_cmd.level, 2) ^ $past(module_variant)))
		else $error("remote dtr write not seen on the line");

	a_cfg_hold: assert property (!reboot && !prog_exit |=> $stable(applied_cfg_ff)) // RQ16 RQ11
		else $error("setting applied outside reboot or programming exit");

	a_rate_button: assert property (prog_mode && prog_by_button |-> active_rate_code == smlc_pkg::BIT_RATE_BUTTON) // RQ17
		else $error("button programming mode not at fixed rate");

	a_rate_period: assert property (##1 bit_period_cycles_ff == smlc_pkg::BIT_CYCLES[$past(active_rate_code)]) // RQ15
		else $error("bit period does not match rate code");

	a_get_reply: assert property (cmd_get |=> pin_ack_ff && pin_rd_level_ff == $past(nxt_rd_level)) // RQ8 RQ14
		else $error("pin read not answered with current level");

	a_rts_remote_set: assert property (!flow_active && cmd_write && pin_cmd.pin == smlc_pkg::PIN_RTS && !reboot // RQ2
		|=> rts_host_ff == $past(pin_cmd.level))
		else $error("remote rts write lost without flow control");

	a_rts_pin_invert: assert property (!flow_active // RQ10 RQ19
		|=> rts_pin == ($past(rts_host_ff) ^ $past(module_variant)))
		else $error("rts pin not the remote level through the inversion");

	a_cmd_ack_ok: assert property (pin_cmd.valid && pin_cmd.op != smlc_pkg::PIN_OP_NOTIFY // RQ7
		|=> pin_ack_ff && pin_ok_ff)
		else $error("pin command not answered ok");

	a_notify_no_ack: assert property (pin_cmd.valid && pin_cmd.op == smlc_pkg::PIN_OP_NOTIFY // RQ7
		|=> !pin_ack_ff && !pin_ok_ff)
		else $error("notification message answered");

	a_reboot_remote_high: assert property (reboot |=> rts_host_ff && dtr_host_ff) // RQ2 RQ12
		else $error("reboot did not restore remote line levels");

	a_notify_rts: assert property (monitor_en[smlc_pkg::MON_RTS] && $changed(rts_level) // RQ8
		|=> notify_change[smlc_pkg::MON_RTS])
		else $error("rts change not notified");

	a_notify_cts: assert property (monitor_en[smlc_pkg::MON_CTS] && $changed(cts_level) // RQ8
		|=> notify_change[smlc_pkg::MON_CTS])
		else $error("cts change not notified");

	a_notify_dtr: assert property (monitor_en[smlc_pkg::MON_DTR] && $changed(dtr_level) // RQ14
		|=> notify_change[smlc_pkg::MON_DTR])
		else $error("dtr change not notified");

	a_notify_quiet: assert property (!$changed(rts_level) && !$changed(cts_level) && !$changed(dtr_level) // RQ8 RQ14
		|=> notify_change == 3'h0)
		else $error("notification without a line change");

	a_rate_escape: assert property (prog_mode && !prog_by_button // RQ17
		|-> active_rate_code == applied_cfg_ff.bit_rate_select)
		else $error("escape programming mode not at selected rate");

	a_rate_routing: assert property (!prog_mode && !bit_rate_override_valid // RQ17
		|-> active_rate_code == applied_cfg_ff.bit_rate_select)
		else $error("routing mode not at selected rate");

	a_dtr_func_reboot: assert property (!reboot |=> $stable(applied_cfg_ff.dtr_function_select)) // RQ11
		else $error("dtr function changed without reboot");

	// ****************************************************************
	// cover points
	// ****************************************************************
	c_rts_throttle: cover property (flow_active && port_open && buf_room ##1 !buf_room);
	c_cts_pause: cover property (flow_active && cts_level ##1 !cts_level);
	c_prog_exit_apply: cover property (prog_mode ##1 !prog_mode);
	c_dtr_connect: cover property (applied_cfg_ff.dtr_function_select && !connection_active ##1 connection_active);
	c_button_prog: cover property (prog_mode && prog_by_button);

endmodule

// >>> rtl/smlc_pkg.sv
/*
 * package for the serial modem line control block: stored settings,
 * remote pin commands, bit-rate table and reset values.
 * assumes a 100 MHz system clock and 4-bit bit-rate codes.
 */
package smlc_pkg;

	// ****************************************************************
	// clock and timing
	// ****************************************************************
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS = 10;

	// ****************************************************************
	// setting codes and values after initialization
	// ****************************************************************
	localparam logic FLOW_CTRL_DISABLED = 1'b0;
	localparam logic FLOW_CTRL_ENABLED = 1'b1;
	localparam logic FLOW_CTRL_RESET = FLOW_CTRL_ENABLED;
	localparam logic DTR_FUNC_IDLE = 1'b0;
	localparam logic DTR_FUNC_CONN = 1'b1;
	localparam logic DTR_FUNC_RESET = DTR_FUNC_IDLE;
	localparam logic [3:0] BIT_RATE_RESET = 4'h5;
	localparam logic [3:0] BIT_RATE_BUTTON = 4'h5;
	localparam logic [3:0] BIT_RATE_LAST = 4'hB;
	localparam logic LINE_HIGH = 1'b1;
	localparam logic LINE_LOW = 1'b0;

	// ****************************************************************
	// buffer threshold
	// ****************************************************************
	localparam logic [15:0] RTS_FREE_MIN = 16'h0014;

	// ****************************************************************
	// remote pin numbers
	// ****************************************************************
	localparam logic [1:0] PIN_RTS = 2'h0;
	localparam logic [1:0] PIN_CTS = 2'h1;
	localparam logic [1:0] PIN_DTR = 2'h2;
	localparam int unsigned MON_RTS = 0;
	localparam int unsigned MON_CTS = 1;
	localparam int unsigned MON_DTR = 2;

	// ****************************************************************
	// bit period in clock cycles for codes 0 to 11
	// ****************************************************************
	localparam logic [19:0] BIT_CYCLES [0:11] = '{
		20'(CLK_HZ / 1200), 20'(CLK_HZ / 2400), 20'(CLK_HZ / 4800),
		20'(CLK_HZ / 9600), 20'(CLK_HZ / 19200), 20'(CLK_HZ / 38400),
		20'(CLK_HZ / 57600), 20'(CLK_HZ / 115200), 20'(CLK_HZ / 150),
		20'(CLK_HZ / 300), 20'(CLK_HZ / 600), 20'(CLK_HZ / 28800)
	};

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		PIN_OP_SET,
		PIN_OP_GET,
		PIN_OP_NOTIFY
	} smlc_pin_op_e;

	typedef struct packed {
		logic valid;
		smlc_pin_op_e op;
		logic [1:0] pin;
		logic level;
	} smlc_pin_cmd_s;

	typedef struct packed {
		logic flow_ctrl_select;
		logic dtr_function_select;
		logic [3:0] bit_rate_select;
	} smlc_cfg_s;

	localparam smlc_cfg_s CFG_RESET = '{FLOW_CTRL_RESET, DTR_FUNC_RESET, BIT_RATE_RESET};

endpackage

// >>> rtl/smlc_line_out.sv
/*
 * registered output stage of one modem line with optional inversion.
 * assumes the caller gives the board-level line level.
 */
`timescale 1ns/100ps
module smlc_line_out (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// line
	input wire logic level,
	input wire logic invert,
	output logic pin_ff
);
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			pin_ff <= smlc_pkg::LINE_HIGH;
		end else begin
			pin_ff <= level ^ invert;
		end
	end
endmodule

// >>> rtl/smlc_change_det.sv
/*
 * change detector for one monitored line level.
 * assumes the level is synchronous to sys_clk.
 */
`timescale 1ns/100ps
module smlc_change_det (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// line
	input wire logic level,
	input wire logic enable,
	output logic change_ff
);
	logic prev_ff;
	logic nxt_change;

	assign nxt_change = enable & (level != prev_ff);

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			prev_ff <= level;
			change_ff <= 1'b0;
		end else begin
			prev_ff <= level;
			change_ff <= nxt_change;
		end
	end
endmodule

// >>> sim/smlc_serial_dev.sv
/*
 * attached serial device on the far side of the modem lines.
 * assumes board-level levels are pin levels xor module_variant.
 */
`timescale 1ns/100ps
module smlc_serial_dev (
	// lines
	input wire logic rts_pin,
	input wire logic module_variant,
	output logic cts_pin,
	// control
	input wire logic pause,
	output logic may_send
);
	// ****************************************************************
	// line behaviour
	// ****************************************************************
	// cts low pauses the bridge
	assign cts_pin = (pause ? smlc_pkg::LINE_LOW : smlc_pkg::LINE_HIGH) ^ module_variant;
	// stop sending while bridge rts low
	assign may_send = rts_pin ^ module_variant;
endmodule

// >>> sim/testbench.sv
/*
 * self-checking testbench of the modem line control block.
 * assumes the design settles one to two cycles after each input change.
 */
`timescale 1ns/100ps
module testbench;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	smlc_pkg::smlc_cfg_s cfg_in = smlc_pkg::CFG_RESET;
	logic flow_ctrl_override_valid = 1'b0;
	logic flow_ctrl_override = 1'b0;
	logic bit_rate_override_valid = 1'b0;
	logic [3:0] bit_rate_override = 4'h0;
	logic module_variant = 1'b0;
	logic half_duplex = 1'b0;
	logic reboot = 1'b0;
	logic prog_mode = 1'b0;
	logic prog_by_button = 1'b0;
	logic port_open = 1'b0;
	logic connection_active = 1'b0;
	logic [15:0] s2n_free_bytes = 16'h0064;
	smlc_pkg::smlc_pin_cmd_s pin_cmd = '0;
	logic pin_ack_ff, pin_ok_ff, pin_rd_level_ff;
	logic [2:0] monitor_en = 3'h7;
	logic [2:0] notify_change;
	logic cts_pin, rts_pin, dtr_pin, tx_allow, pause = 1'b0, may_send;
	smlc_pkg::smlc_cfg_s applied_cfg_ff;
	logic [3:0] active_rate_code;
	logic [19:0] bit_period_cycles_ff;
	int n_errors = 0;
	int check_count = 0;
	int rates [0:11] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200, 150, 300, 600, 28800};

	always #5 sys_clk = ~sys_clk;

	smlc_line_control dut (.sys_clk, .reset_n, .cfg_in, .flow_ctrl_override_valid, .flow_ctrl_override,
		.bit_rate_override_valid, .bit_rate_override, .module_variant, .half_duplex, .reboot, .prog_mode,
		.prog_by_button, .port_open, .connection_active, .s2n_free_bytes, .pin_cmd, .pin_ack_ff, .pin_ok_ff,
		.pin_rd_level_ff, .monitor_en, .notify_change, .cts_pin, .rts_pin, .dtr_pin, .tx_allow,
		.applied_cfg_ff, .active_rate_code, .bit_period_cycles_ff);

	smlc_serial_dev peer (.rts_pin, .module_variant, .cts_pin, .pause, .may_send);

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic end_sim;
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic cmd(input smlc_pkg::smlc_pin_op_e op, input logic [1:0] pin, input logic lvl, output logic rd);
		pin_cmd = '{1'b1, op, pin, lvl};
		step(1);
		pin_cmd = '0;
		rd = pin_rd_level_ff;
		chk(pin_ack_ff, 20'(op != smlc_pkg::PIN_OP_NOTIFY));
		chk(pin_ok_ff, 20'(op != smlc_pkg::PIN_OP_NOTIFY));
		step(3);
	endtask

	task automatic wait_note(input int b);
		int i;
		for (i = 0; i < 8 && notify_change[b] !== 1'b1; i++)
			step(1);
		chk(20'(i < 8), 20'h0_0001);
		if (i == 8)
			end_sim();
	endtask

	task automatic do_reboot;
		reboot = 1'b1;
		step(1);
		reboot = 1'b0;
		step(3);
	endtask

	initial begin
		repeat (60000) @(posedge sys_clk);
		n_errors++;
		end_sim();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		logic rd;
		int exp_code;
		step(17);
		reset_n = 1'b1;
		step(2);
		chk(applied_cfg_ff, smlc_pkg::CFG_RESET);
		chk(bit_period_cycles_ff, smlc_pkg::CLK_HZ / rates[5]);
		chk(dtr_pin, 1);
		chk(rts_pin, 0);
		port_open = 1'b1;
		s2n_free_bytes = 16'h0014;
		step(3);
		chk(rts_pin, 1);
		chk(may_send, 1);
		s2n_free_bytes = 16'h0013;
		step(3);
		chk(rts_pin, 0);
		chk(may_send, 0);
		s2n_free_bytes = 16'h0014;
		wait_note(smlc_pkg::MON_RTS);
		cmd(smlc_pkg::PIN_OP_SET, smlc_pkg::PIN_RTS, 1'b0, rd);
		chk(rts_pin, 1);
		cmd(smlc_pkg::PIN_OP_NOTIFY, smlc_pkg::PIN_RTS, 1'b0, rd);
		chk(rts_pin, 1);
		pause = 1'b1;
		step(3);
		chk(tx_allow, 0);
		cmd(smlc_pkg::PIN_OP_GET, smlc_pkg::PIN_CTS, 1'b1, rd);
		chk(rd, 0);
		pause = 1'b0;
		step(1);
		chk(tx_allow, 1);
		wait_note(smlc_pkg::MON_CTS);
		half_duplex = 1'b1;
		pause = 1'b1;
		s2n_free_bytes = 16'h0000;
		step(3);
		chk(tx_allow, 1);
		chk(rts_pin, 1);
		half_duplex = 1'b0;
		step(3);
		chk(tx_allow, 0);
		flow_ctrl_override_valid = 1'b1;
		step(3);
		chk(tx_allow, 1);
		chk(rts_pin, 1);
		cmd(smlc_pkg::PIN_OP_SET, smlc_pkg::PIN_RTS, 1'b0, rd);
		chk(rts_pin, 0);
		cmd(smlc_pkg::PIN_OP_NOTIFY, smlc_pkg::PIN_RTS, 1'b1, rd);
		chk(rts_pin, 1);
		cmd(smlc_pkg::PIN_OP_GET, smlc_pkg::PIN_RTS, 1'b0, rd);
		chk(rd, 1);
		module_variant = 1'b1;
		step(3);
		chk(rts_pin, 0);
		chk(dtr_pin, 0);
		module_variant = 1'b0;
		pause = 1'b0;
		flow_ctrl_override_valid = 1'b0;
		cmd(smlc_pkg::PIN_OP_SET, smlc_pkg::PIN_DTR, 1'b0, rd);
		chk(dtr_pin, 0);
		cmd(smlc_pkg::PIN_OP_GET, smlc_pkg::PIN_DTR, 1'b1, rd);
		chk(rd, 0);
		cfg_in.dtr_function_select = 1'b1;
		cfg_in.flow_ctrl_select = 1'b0;
		prog_mode = 1'b1;
		step(2);
		prog_mode = 1'b0;
		step(3);
		chk(applied_cfg_ff.flow_ctrl_select, 0);
		chk(applied_cfg_ff.dtr_function_select, 0);
		do_reboot();
		chk(applied_cfg_ff.dtr_function_select, 1);
		chk(dtr_pin, 0);
		connection_active = 1'b1;
		step(3);
		chk(dtr_pin, 1);
		connection_active = 1'b0;
		wait_note(smlc_pkg::MON_DTR);
		exp_code = 5;
		for (int c = 0; c < 13; c++) begin
			cfg_in.bit_rate_select = c[3:0];
			step(3);
			chk(active_rate_code, 20'(exp_code));
			do_reboot();
			exp_code = (c < 12) ? c : 11;
			chk(active_rate_code, 20'(exp_code));
			chk(bit_period_cycles_ff, smlc_pkg::CLK_HZ / rates[exp_code]);
		end
		cfg_in.bit_rate_select = 4'h3;
		prog_mode = 1'b1;
		step(3);
		chk(active_rate_code, 11);
		prog_mode = 1'b0;
		step(3);
		chk(active_rate_code, 3);
		prog_mode = 1'b1;
		prog_by_button = 1'b1;
		step(3);
		chk(bit_period_cycles_ff, smlc_pkg::CLK_HZ / 38400);
		prog_mode = 1'b0;
		prog_by_button = 1'b0;
		bit_rate_override_valid = 1'b1;
		bit_rate_override = 4'h7;
		step(3);
		chk(active_rate_code, 7);
		bit_rate_override = 4'hC;
		step(1);
		chk(active_rate_code, 3);
		monitor_en = 3'h0;
		connection_active = 1'b1;
		step(1);
		chk(notify_change, 0);
		monitor_en = 3'h7;
		reset_n = 1'b0;
		step(2);
		reset_n = 1'b1;
		step(2);
		chk(applied_cfg_ff, smlc_pkg::CFG_RESET);
		end_sim();
	end
endmodule
